// *** design/bctk_params.svh ***
`ifndef BCTK_PARAMS_SVH
`define BCTK_PARAMS_SVH

// Byte addresses on the register bus
`define BCTK_ADDR_VALUE   8'h00
`define BCTK_ADDR_CTRL    8'h04
`define BCTK_ADDR_STATUS  8'h08
`define BCTK_ADDR_ALARM   8'h0C
`define BCTK_ADDR_SUBSEC  8'h10

// Value pointer codes
`define BCTK_PTR_MINSEC   2'h0
`define BCTK_PTR_WDHOUR   2'h1
`define BCTK_PTR_MONDAY   2'h2
`define BCTK_PTR_YEAR     2'h3

// Control word fields
`define BCTK_CTL_PTR      1:0
`define BCTK_CTL_UNLOCK   2
`define BCTK_CTL_OUT_EN   3
`define BCTK_CTL_OUT_SEL  4
`define BCTK_CTL_ALM_EN   5
`define BCTK_CTL_CAL      15:8

// Alarm word fields
`define BCTK_ALM_HOUR     21:16
`define BCTK_ALM_MIN      14:8
`define BCTK_ALM_SEC      6:0

// Reset values: midnight, first of January 2000
`define BCTK_RST_DAY_ONE  4'h1
`define BCTK_RST_MON_ONE  4'h1
`define BCTK_RST_WEEKDAY_DIGIT     3'h0

// Reference clock 50 MHz, crystal timebase 32.768 kHz (both in Hz)
`define BCTK_REF_HZ       26'h2FA_F080
`define BCTK_XTAL_HZ      26'h000_8000
`define BCTK_SEC_TICKS    32768
`define BCTK_HOUR_SECS    12'hE0F

`endif

// *** design/bctk_pkg.sv ***
package bctk_pkg;

	typedef logic [15:0] bctk_word_t;
	typedef logic [1:0]  bctk_ptr_t;

	typedef struct packed {
		logic [3:0] yr_t;
		logic [3:0] yr_o;
		logic       mo_t;
		logic [3:0] mo_o;
		logic [1:0] dy_t;
		logic [3:0] dy_o;
		logic [2:0] wd;
		logic [1:0] hr_t;
		logic [3:0] hr_o;
		logic [2:0] mn_t;
		logic [3:0] mn_o;
		logic [2:0] sc_t;
		logic [3:0] sc_o;
	} bctk_time_s;

	typedef enum logic {
		BCTK_OUT_ALARM,
		BCTK_OUT_SECCLK
	} bctk_outsel_e;

endpackage

// *** design/bctk_cal_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface bctk_cal_if;
	import bctk_pkg::*;
	logic       sec_tick;
	logic       wr;
	bctk_ptr_t  wr_ptr;
	bctk_word_t wr_data;
	bctk_word_t yr_word;
	bctk_word_t md_word;
	bctk_word_t wh_word;
	bctk_word_t ms_word;

	modport ctrl (
		output sec_tick, wr, wr_ptr, wr_data,
		input  yr_word, md_word, wh_word, ms_word
	);
	modport cal (
		input  sec_tick, wr, wr_ptr, wr_data,
		output yr_word, md_word, wh_word, ms_word
	);
endinterface
`default_nettype wire

// *** design/bctk_calendar.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "bctk_params.svh"
module bctk_calendar (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Link to the control logic
	bctk_cal_if.cal  cal
);
	import bctk_pkg::*;

	bctk_time_s time_q;
	bctk_time_s time_d;

	// Two BCD digits plus one
	function automatic logic [7:0] bcd2_inc(input logic [3:0] t,
		input logic [3:0] o);
		return (o == 4'h9) ? {4'(t + 4'h1), 4'h0} : {t, 4'(o + 4'h1)};
	endfunction

	// Two-digit year divisible by four, 00 included
	function automatic logic leap_year(input logic [3:0] t,
		input logic [3:0] o);
		return t[0] ? (o == 4'h2 || o == 4'h6)
			: (o == 4'h0 || o == 4'h4 || o == 4'h8);
	endfunction

	// Last day of the month as two BCD digits
	function automatic logic [5:0] last_day(input bctk_time_s t);
		logic [4:0] m;
		m = {t.mo_t, t.mo_o};
		if (m == 5'h02)
			return leap_year(t.yr_t, t.yr_o) ? 6'h29 : 6'h28;
		else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
			return 6'h30;
		else
			return 6'h31;
	endfunction

	wire logic [7:0] sc_inc = bcd2_inc({1'b0, time_q.sc_t}, time_q.sc_o);
	wire logic [7:0] mn_inc = bcd2_inc({1'b0, time_q.mn_t}, time_q.mn_o);
	wire logic [7:0] hr_inc = bcd2_inc({2'b00, time_q.hr_t}, time_q.hr_o);
	wire logic [7:0] dy_inc = bcd2_inc({2'b00, time_q.dy_t}, time_q.dy_o);
	wire logic [7:0] mo_inc = bcd2_inc({3'b000, time_q.mo_t}, time_q.mo_o);
	wire logic [7:0] yr_inc = bcd2_inc(time_q.yr_t, time_q.yr_o);

	wire logic s_wrap = {time_q.sc_t, time_q.sc_o} == 7'h59;
	wire logic m_wrap = s_wrap && {time_q.mn_t, time_q.mn_o} == 7'h59;
	wire logic h_wrap = m_wrap && {time_q.hr_t, time_q.hr_o} == 6'h23;
	wire logic d_wrap = h_wrap && {time_q.dy_t, time_q.dy_o} == last_day(time_q);
	wire logic o_wrap = d_wrap && {time_q.mo_t, time_q.mo_o} == 5'h12;

	always_comb begin
		time_d = time_q;
		if (cal.wr) begin
			case (cal.wr_ptr)
				`BCTK_PTR_YEAR: begin
					time_d.yr_t = cal.wr_data[7:4];
					time_d.yr_o = cal.wr_data[3:0];
				end
				`BCTK_PTR_MONDAY: begin
					time_d.mo_t = cal.wr_data[12];
					time_d.mo_o = cal.wr_data[11:8];
					time_d.dy_t = cal.wr_data[5:4];
					time_d.dy_o = cal.wr_data[3:0];
				end
				`BCTK_PTR_WDHOUR: begin
					time_d.wd   = cal.wr_data[10:8];
					time_d.hr_t = cal.wr_data[5:4];
					time_d.hr_o = cal.wr_data[3:0];
				end
				default: begin
					time_d.mn_t = cal.wr_data[14:12];
					time_d.mn_o = cal.wr_data[11:8];
					time_d.sc_t = cal.wr_data[6:4];
					time_d.sc_o = cal.wr_data[3:0];
				end
			endcase
		end else if (cal.sec_tick) begin
			{time_d.sc_t, time_d.sc_o} = s_wrap ? 7'h00 : sc_inc[6:0];
			if (s_wrap)
				{time_d.mn_t, time_d.mn_o} = m_wrap ? 7'h00 : mn_inc[6:0];
			if (m_wrap)
				{time_d.hr_t, time_d.hr_o} = h_wrap ? 6'h00 : hr_inc[5:0];
			if (h_wrap) begin
				time_d.wd = (time_q.wd == 3'h6) ? 3'h0 : 3'(time_q.wd + 3'h1);
				{time_d.dy_t, time_d.dy_o} = d_wrap ? 6'h01 : dy_inc[5:0];
			end
			if (d_wrap)
				{time_d.mo_t, time_d.mo_o} = o_wrap ? 5'h01 : mo_inc[4:0];
			// Past 2099 the year folds back to 2000
			if (o_wrap)
				{time_d.yr_t, time_d.yr_o} = (yr_inc[7:4] == 4'hA)
					? 8'h00 : yr_inc;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			time_q      <= '0;
			time_q.dy_o <= `BCTK_RST_DAY_ONE;
			time_q.mo_o <= `BCTK_RST_MON_ONE;
			time_q.wd   <= `BCTK_RST_WEEKDAY_DIGIT;
		end else begin
			time_q <= time_d;
		end
	end

	// Unused positions read as zero
	assign cal.yr_word = {8'h00, time_q.yr_t, time_q.yr_o};
	assign cal.md_word = {3'b000, time_q.mo_t, time_q.mo_o,
		2'b00, time_q.dy_t, time_q.dy_o};
	assign cal.wh_word = {5'b00000, time_q.wd,
		2'b00, time_q.hr_t, time_q.hr_o};
	assign cal.ms_word = {1'b0, time_q.mn_t, time_q.mn_o,
		1'b0, time_q.sc_t, time_q.sc_o};
endmodule
`default_nettype wire

// *** design/bctk_top.sv ***
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "bctk_params.svh"
module bctk_top #(
	parameter int unsigned SEC_TICKS = `BCTK_SEC_TICKS
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// APB slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Alarm or seconds clock pin
	output logic             time_pin_out,
	output logic             time_pin_oe
);
	import bctk_pkg::*;

	localparam logic [16:0] SEC_LEN  = 17'(SEC_TICKS);
	localparam logic [16:0] HALF_LEN = 17'(SEC_TICKS / 2);

	// Byte-lane merge of a write onto the current word
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction

	bctk_cal_if cal_bus ();

	bctk_calendar u_calendar (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.cal     (cal_bus.cal)
	);

	// Register state
	logic [31:0]  prdata_q;
	logic         pready_q;
	logic         pslverr_q;
	bctk_ptr_t    ptr_q;
	logic         unlock_q;
	logic         out_en_q;
	bctk_outsel_e out_sel_q;
	logic         alm_en_q;
	logic [7:0]   cal_q;
	logic [5:0]   alm_hour_q;
	logic [6:0]   alm_min_q;
	logic [6:0]   alm_sec_q;

	// Timebase state
	logic [25:0]  acc_q;
	logic         xtal_en_q;
	logic [16:0]  sub_q;
	logic         sec_tick_q;
	logic         tick_late_q;
	logic         tick_seen_q;
	logic         half_q;
	logic [11:0]  hour_secs_q;
	logic         cal_pend_q;
	logic         alm_hold_q;
	logic         pin_q;
	logic         pin_oe_q;

	// Bus decode
	wire logic setup    = psel && !penable;
	wire logic access   = psel && penable && pready_q;
	wire logic bus_wr   = access && pwrite;
	wire logic sel_val  = paddr == `BCTK_ADDR_VALUE;
	wire logic sel_ctl  = paddr == `BCTK_ADDR_CTRL;
	wire logic sel_sts  = paddr == `BCTK_ADDR_STATUS;
	wire logic sel_alm  = paddr == `BCTK_ADDR_ALARM;
	wire logic sel_sub  = paddr == `BCTK_ADDR_SUBSEC;
	wire logic mapped   = sel_val || sel_ctl || sel_sts || sel_alm || sel_sub;

	// Window selection by pointer
	wire bctk_word_t win_word =
		(ptr_q == `BCTK_PTR_YEAR)   ? cal_bus.yr_word :
		(ptr_q == `BCTK_PTR_MONDAY) ? cal_bus.md_word :
		(ptr_q == `BCTK_PTR_WDHOUR) ? cal_bus.wh_word :
		cal_bus.ms_word;

	wire logic [31:0] ctl_word = {16'h0000, cal_q, 2'b00, alm_en_q,
		out_sel_q, out_en_q, unlock_q, ptr_q};
	wire logic [31:0] sts_word = {30'h0000_0000, alm_hold_q, half_q};
	wire logic [31:0] alm_word = {10'h000, alm_hour_q, 1'b0, alm_min_q,
		1'b0, alm_sec_q};
	wire logic [31:0] sub_word = {15'h0000, sub_q};

	wire logic [31:0] rd_mux =
		sel_val ? {16'h0000, win_word} :
		sel_ctl ? ctl_word :
		sel_sts ? sts_word :
		sel_alm ? alm_word :
		sel_sub ? sub_word : 32'h0000_0000;

	wire logic [31:0] val_new = lane_merge({16'h0000, win_word}, pwdata, pstrb);
	wire logic [31:0] ctl_new = lane_merge(ctl_word, pwdata, pstrb);
	wire logic [31:0] alm_new = lane_merge(alm_word, pwdata, pstrb);

	// Field views of the merged control and alarm words
	wire bctk_ptr_t   ctl_ptr_new  = ctl_new[`BCTK_CTL_PTR];
	wire logic        ctl_unl_new  = ctl_new[`BCTK_CTL_UNLOCK];
	wire logic        ctl_oe_new   = ctl_new[`BCTK_CTL_OUT_EN];
	wire logic        ctl_sel_new  = ctl_new[`BCTK_CTL_OUT_SEL];
	wire logic        ctl_alm_new  = ctl_new[`BCTK_CTL_ALM_EN];
	wire logic [7:0]  ctl_cal_new  = ctl_new[`BCTK_CTL_CAL];
	wire logic [5:0]  alm_hour_new = alm_new[`BCTK_ALM_HOUR];
	wire logic [6:0]  alm_min_new  = alm_new[`BCTK_ALM_MIN];
	wire logic [6:0]  alm_sec_new  = alm_new[`BCTK_ALM_SEC];
	wire logic        ctl_wr       = bus_wr && sel_ctl;
	wire logic        alm_wr       = bus_wr && sel_alm;

	// Locked writes to the window are dropped without an error
	wire logic win_wr   = bus_wr && sel_val && unlock_q;
	// A tick that meets a window write is held back a cycle, not lost,
	// so software updates never cost the clock a second
	wire logic tick_now = sec_tick_q || tick_late_q;
	// Step really taken by the calendar this cycle
	wire logic stepped  = tick_now && !win_wr;

	assign cal_bus.wr       = win_wr;
	assign cal_bus.wr_ptr   = ptr_q;
	assign cal_bus.wr_data  = val_new[15:0];
	assign cal_bus.sec_tick = tick_now;

	// Fractional divider: 50 MHz down to 32.768 kHz tick enables
	wire logic [25:0] acc_sum = acc_q + `BCTK_XTAL_HZ;
	wire logic        xtal_en = acc_sum >= `BCTK_REF_HZ;
	wire logic [25:0] acc_d   = xtal_en ? 26'(acc_sum - `BCTK_REF_HZ) : acc_sum;

	// Once an hour one second is stretched or shortened by the trim value
	wire logic [16:0] cal_ext = {{9{cal_q[7]}}, cal_q};
	wire logic [16:0] sec_len = cal_pend_q ? 17'(SEC_LEN - cal_ext) : SEC_LEN;
	wire logic        sec_end = xtal_en_q && (sub_q == 17'(sec_len - 17'h0_0001));

	// Compared one cycle after the step, once the new time is visible
	wire logic hour_hit  = cal_bus.wh_word[5:0] == alm_hour_q;
	wire logic min_hit   = cal_bus.ms_word[14:8] == alm_min_q;
	wire logic sec_hit   = cal_bus.ms_word[6:0] == alm_sec_q;
	wire logic alm_match = tick_seen_q && alm_en_q
		&& hour_hit && min_hit && sec_hit;

	// Seconds clock is high in the first half of each second
	wire logic pin_src = (out_sel_q == BCTK_OUT_SECCLK) ? !half_q : alm_hold_q;
	wire logic refuse  = setup && !mapped;

	// Bus answer: ready in the first access cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= refuse;
			if (setup)
				prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	// Control and alarm registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_q     <= `BCTK_PTR_MINSEC;
			unlock_q  <= 1'b0;
			out_en_q  <= 1'b0;
			out_sel_q <= BCTK_OUT_ALARM;
			alm_en_q  <= 1'b0;
			cal_q     <= 8'h00;
		end else if (ctl_wr) begin
			ptr_q     <= ctl_ptr_new;
			unlock_q  <= ctl_unl_new;
			out_en_q  <= ctl_oe_new;
			out_sel_q <= bctk_outsel_e'(ctl_sel_new);
			alm_en_q  <= ctl_alm_new;
			cal_q     <= ctl_cal_new;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			alm_hour_q <= 6'h00;
			alm_min_q  <= 7'h00;
			alm_sec_q  <= 7'h00;
		end else if (alm_wr) begin
			alm_hour_q <= alm_hour_new;
			alm_min_q  <= alm_min_new;
			alm_sec_q  <= alm_sec_new;
		end
	end

	// Timebase and sub-second count
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_q     <= 26'h000_0000;
			xtal_en_q <= 1'b0;
		end else begin
			acc_q     <= acc_d;
			xtal_en_q <= xtal_en;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sub_q      <= 17'h0_0000;
			sec_tick_q <= 1'b0;
			half_q     <= 1'b0;
		end else begin
			sec_tick_q <= sec_end;
			half_q     <= sub_q >= HALF_LEN;
			if (sec_end)
				sub_q <= 17'h0_0000;
			else if (xtal_en_q)
				sub_q <= 17'(sub_q + 17'h0_0001);
		end
	end

	// Deferred tick after a colliding window write
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_late_q <= 1'b0;
		end else begin
			tick_late_q <= tick_now && win_wr;
		end
	end

	// Hourly trim scheduling
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hour_secs_q <= 12'h000;
			cal_pend_q  <= 1'b0;
		end else begin
			if (sec_tick_q)
				hour_secs_q <= (hour_secs_q == `BCTK_HOUR_SECS)
					? 12'h000 : 12'(hour_secs_q + 12'h001);
			if (sec_tick_q && hour_secs_q == `BCTK_HOUR_SECS)
				cal_pend_q <= 1'b1;
			else if (sec_end)
				cal_pend_q <= 1'b0;
		end
	end

	// Alarm pulse lasts for the first half of the matching second
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_seen_q <= 1'b0;
			alm_hold_q  <= 1'b0;
		end else begin
			tick_seen_q <= stepped;
			if (alm_match)
				alm_hold_q <= 1'b1;
			else if (half_q)
				alm_hold_q <= 1'b0;
		end
	end

	// Output pin
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q    <= 1'b0;
			pin_oe_q <= 1'b0;
		end else begin
			pin_oe_q <= out_en_q;
			pin_q    <= out_en_q && pin_src;
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign time_pin_out = pin_q;
	assign time_pin_oe  = pin_oe_q;
endmodule
`default_nettype wire

// *** test/bctk_top_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module bctk_top_chk #(
	parameter int unsigned SEC_TICKS = 32768
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// Register bus
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Output pin
	input wire logic        time_pin_out,
	input wire logic        time_pin_oe
);
	wire setup_w = psel && !penable;
	wire mapped_w = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	wire ctl_wr_w = pready && pwrite && paddr == 8'h04;

	default clocking dcb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	ready_once_a: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	zero_wait_a: assert property (setup_w |=> pready)
		else $error("no answer in first access cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside an access cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	unmapped_err_a: assert property (setup_w && !mapped_w |=> pslverr)
		else $error("unmapped address not refused");
	mapped_ok_a: assert property (setup_w && mapped_w |=> !pslverr)
		else $error("mapped address refused");
	err_read_zero_a: assert property (pready && pslverr && !pwrite
		|-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	rdata_hold_a: assert property (!psel |=> $stable(prdata))
		else $error("read data moved while idle");
	pin_off_a: assert property (!time_pin_oe |-> !time_pin_out)
		else $error("pin driven high while disabled");
	oe_follow_a: assert property (ctl_wr_w && !pslverr && pstrb[0]
		|-> ##2 time_pin_oe == $past(pwdata[3], 2))
		else $error("pin enable does not follow control");

	// Main scenarios
	cov_refused: cover property (pready && pslverr);
	cov_pin: cover property ($rose(time_pin_out));
	cov_write: cover property (pready && pwrite && paddr == 8'h00);
endmodule

bind bctk_top bctk_top_chk #(.SEC_TICKS(SEC_TICKS)) u_chk (
	.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.time_pin_out(time_pin_out), .time_pin_oe(time_pin_oe)
);
`default_nettype wire

// *** test/test_bcd_time_calendar_keeper.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_bcd_time_calendar_keeper;
	logic        ref_clk;
	logic        rst_b;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        oe;
	logic        err;
	logic [31:0] ctl;
	logic [31:0] rd;
	logic [31:0] rnd;
	logic [23:0] ex;
	int          mismatches;
	int          n_compared;
	int          cycles;
	int          seed;
	int          i;
	int          k;
	logic [15:0] msk [4] = '{16'h7F7F, 16'h073F, 16'h1F3F, 16'h00FF};
	logic [7:0]  t_yr [5] = '{8'h04, 8'h01, 8'h99, 8'h00, 8'h23};
	logic [15:0] t_md [5] = '{16'h0228, 16'h0228, 16'h1231, 16'h0228,
		16'h0930};
	int          t_wd [5] = '{6, 3, 5, 1, 0};
	// Control bits 5:3 are alarm enable, pin select, pin enable
	logic [2:0]  mode [5] = '{3'h3, 3'h0, 3'h5, 3'h0, 3'h0};

	bctk_top #(.SEC_TICKS(8)) u_dut (
		.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.time_pin_out(pin), .time_pin_oe(oe)
	);

	initial begin
		ref_clk = 0;
		forever #10 ref_clk = ~ref_clk;
	end

	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 90000) begin
			mismatches++;
			print_verdict();
		end
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int t;
		psel <= 1;
		penable <= 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		t = 0;
		do begin
			@(posedge ref_clk);
			t++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		chk("wait states", 1, t);
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
	endtask

	task wv(input logic [1:0] p, input logic [15:0] d);
		ctl[1:0] = p;
		apb(8'h04, 1, ctl);
		apb(8'h00, 1, {16'h0000, d});
	endtask

	task rv(input logic [1:0] p);
		ctl[1:0] = p;
		apb(8'h04, 1, ctl);
		apb(8'h00, 0, 32'h0000_0000);
	endtask

	// Year, month/day after one step past midnight
	function automatic logic [23:0] nxt(input logic [7:0] yr,
		input logic [15:0] md);
		int y, m, d, l;
		y = yr[7:4] * 10 + yr[3:0];
		m = md[12] * 10 + md[11:8];
		d = md[5:4] * 10 + md[3:0];
		l = (m == 2) ? 28 + (y % 4 == 0) : 30 + ((m + m / 8) % 2);
		d = (d == l) ? 1 : d + 1;
		if (d == 1)
			m = m % 12 + 1;
		if (d == 1 && m == 1)
			y = (y + 1) % 100;
		return {4'(y / 10), 4'(y % 10), 3'h0, 1'(m / 10), 4'(m % 10),
			2'h0, 2'(d / 10), 4'(d % 10)};
	endfunction

	initial begin
		seed = 3;
		rst_b = 0;
		psel = 0;
		penable = 0;
		paddr = 8'h00;
		pwrite = 0;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		ctl = 32'h0000_0000;
		repeat (20) @(posedge ref_clk);
		rst_b <= 1;
		@(posedge ref_clk);
		apb(8'h04, 0, 32'h0000_0000);
		chk("control", 0, rd);
		wv(2'h3, 16'h0055);
		rv(2'h3);
		chk("locked year", 0, rd);
		rv(2'h2);
		chk("reset month day", 32'h0101, rd);
		rv(2'h1);
		chk("reset weekday hour", 0, rd);
		apb(8'h14, 0, 32'h0000_0000);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
		apb(8'h14, 1, 32'hFFFF_FFFF);
		chk("unmapped write err", 1, err);
		ctl[2] = 1;
		for (i = 0; i < 12; i++) begin
			k = 3 - i % 3;
			rnd = $random(seed);
			wv(k[1:0], rnd[15:0]);
			rv(k[1:0]);
			chk("value word", rnd & msk[k], rd);
		end
		// Lane strobes: only the low byte of the day word may change
		wv(2'h2, 16'h0101);
		pstrb <= 4'h1;
		apb(8'h00, 1, 32'h0000_1215);
		pstrb <= 4'hF;
		rv(2'h2);
		chk("strobe merge", 32'h0000_0115, rd);
		for (i = 0; i < 5; i++) begin
			ctl[5:3] = mode[i];
			wv(2'h3, {8'h00, t_yr[i]});
			wv(2'h2, t_md[i]);
			wv(2'h1, {5'h00, 3'(t_wd[i]), 8'h23});
			// Seconds last, so an early step cannot carry
			wv(2'h0, 16'h5959);
			k = 0;
			do begin
				apb(8'h00, 0, 32'h0000_0000);
				k++;
			end while (rd[15:0] === 16'h5959 && k < 5000);
			chk("min sec", 0, rd);
			apb(8'h08, 0, 32'h0000_0000);
			chk("half early", 0, rd[0]);
			chk("alarm", mode[i][2], rd[1]);
			chk("pin enable", mode[i][0], oe);
			chk("pin", mode[i][0] & (mode[i][1] | mode[i][2]), pin);
			ex = nxt(t_yr[i], t_md[i]);
			rv(2'h1);
			chk("weekday hour", {21'h0, 3'((t_wd[i] + 1) % 7), 8'h00}, rd);
			rv(2'h2);
			chk("month day", ex[15:0], rd);
			rv(2'h3);
			chk("year", ex[23:16], rd);
			if (i == 0) begin
				k = 0;
				do begin
					apb(8'h08, 0, 32'h0000_0000);
					k++;
				end while (rd[0] !== 1'b1 && k < 3000);
				chk("half late", 1, rd[0]);
			end
		end
		print_verdict();
	end
endmodule
`default_nettype wire
